//--- hdl/dlic_pkg.sv
// package: register map, bit map and carrier types of the dual-level interrupt controller
// Operation
// - all level registers share one bit map; bit0 summary, bit1 soft, bits2-5 timers
// - bits 7-14 and 16-18 carry the remaining peripheral sources in fixed order
// - raw status follows each source request level and is read-only
// - normal enable bit 1 lets a source raise the normal request, 0 blocks it
// - enable-clear is write-only; each written 1 clears that enable bit only
// - masked status is read-only and equals raw status AND enable mask outside the summary and soft bits
// - all 32 normal masked bits are OR-ed into the normal request line
// - no priority encoding and no vector; software picks the source
// - fast level has its own raw, enable, clear and masked registers
// - fast line is OR of fast masked bits 31..1, also shown as bit 0
// - writing 1 to a fast enable bit clears the same normal enable bit
// - writing 1 to a normal enable bit clears the same fast enable bit
// - a source may be disabled on both levels at once
// - soft interrupts are non-maskable, injected via the soft config register
// - soft config bit 2 drives bit 1 of fast raw and fast masked status
// - soft config bit 1 drives bit 1 of normal raw and masked; others reserved
// - bit 1 has no effect in enable and enable-clear registers
// - enabled interrupt in power-down with core recognition off wakes peripherals only
package dlic_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned NSRC = 15;
  localparam logic [AW-1:0] OFF_IRQ_RAW = 8'h00;
  localparam logic [AW-1:0] OFF_IRQ_EN = 8'h04;
  localparam logic [AW-1:0] OFF_IRQ_CLR = 8'h08;
  localparam logic [AW-1:0] OFF_IRQ_MSK = 8'h0C;
  localparam logic [AW-1:0] OFF_FIQ_RAW = 8'h10;
  localparam logic [AW-1:0] OFF_FIQ_EN = 8'h14;
  localparam logic [AW-1:0] OFF_FIQ_CLR = 8'h18;
  localparam logic [AW-1:0] OFF_FIQ_MSK = 8'h1C;
  localparam logic [AW-1:0] OFF_SOFT_CFG = 8'h20;
  localparam logic [AW-1:0] WORD_MASK = 8'hFC;
  localparam int unsigned BIT_SUM = 0;
  localparam int unsigned BIT_SOFT = 1;
  localparam int unsigned CFG_SOFT_IRQ = 1;
  localparam int unsigned CFG_SOFT_FIQ = 2;
  localparam logic [DW-1:0] SRC_MASK = 32'h0007_7FBC; // bits 6,15 stay zero
  localparam logic [DW-1:0] CFG_MASK = 32'h0000_0006;
  localparam logic [DW-1:0] ZERO32 = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] PWR_PERIPH_ONLY = 8'h71;
  localparam logic [7:0] PWR_NONE = 8'h00;

  // source index to map position: timers, then gap at 6, then gap at 15
  function automatic int unsigned src_bit(input int unsigned i);
    if (i < 4) begin
      return i + 2;
    end else if (i < 12) begin
      return i + 3;
    end else begin
      return i + 4;
    end
  endfunction

  // peripheral requests, timer0 in the lowest bit
  typedef struct packed {
    logic ext_in5;
    logic ext_in4;
    logic high_volt;
    logic ext_in1;
    logic ext_in0;
    logic spi;
    logic uart;
    logic converter;
    logic pll_lock;
    logic flash;
    logic serial_bus;
    logic [3:0] timer;
  } dlic_src_s;

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } dlic_axi_req_s;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DW-1:0] rdata;
    logic [1:0] rresp;
  } dlic_axi_rsp_s;
endpackage

//--- hdl/dlic_sync.sv
// two-stage synchroniser for a vector of source request levels
`timescale 1ns/1ns
`default_nettype none
module dlic_sync #(
  parameter int unsigned W = 15
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dlic_sync_s;

  dlic_sync_s s;
  dlic_sync_s next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;
endmodule
`default_nettype wire

//--- hdl/dlic_reqline.sv
// registered OR of a masked status word into one request level
`timescale 1ns/1ns
`default_nettype none
module dlic_reqline #(
  parameter int unsigned LO = 0
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [31:0] masked, // masked status word
  output logic req // request level to the core
);
  typedef struct packed {
    logic req;
  } dlic_req_s;

  dlic_req_s s;
  dlic_req_s next_s;

  // plain OR, no priority or vector
  always_comb begin
    next_s.req = |masked[31:LO];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign req = s.req;
endmodule
`default_nettype wire

//--- hdl/dlic_top.sv
// dual-level interrupt controller with axi4-lite register slave
`timescale 1ns/1ns
`default_nettype none
module dlic_top (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire dlic_pkg::dlic_axi_req_s axi_req, // bus master signals
  output dlic_pkg::dlic_axi_rsp_s axi_rsp, // bus slave signals
  input wire dlic_pkg::dlic_src_s src, // peripheral request levels
  input wire logic power_down, // device is in power-down
  input wire logic core_irq_off, // core interrupt recognition off
  output logic irq_req, // normal request level to the core
  output logic fiq_req, // fast request level to the core
  output logic periph_wake, // one-cycle peripheral wake pulse
  output logic core_hold, // core kept down until reset
  output logic [7:0] power_ctl // power setting applied at wake
);
  typedef struct packed {
    logic aw_have;
    logic [dlic_pkg::AW-1:0] aw_addr;
    logic w_have;
    logic [dlic_pkg::DW-1:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [dlic_pkg::DW-1:0] rdata;
    logic [1:0] rresp;
    logic [dlic_pkg::DW-1:0] irq_en;
    logic [dlic_pkg::DW-1:0] fiq_en;
    logic [dlic_pkg::DW-1:0] soft_cfg;
    logic wake;
    logic hold;
    logic [7:0] pctl;
  } dlic_state_s;

  dlic_state_s s;
  dlic_state_s next_s;

  logic [dlic_pkg::NSRC-1:0] src_sync;
  logic [dlic_pkg::DW-1:0] src_map;
  logic [dlic_pkg::DW-1:0] irq_raw;
  logic [dlic_pkg::DW-1:0] irq_masked;
  logic [dlic_pkg::DW-1:0] fiq_raw;
  logic [dlic_pkg::DW-1:0] fiq_masked;
  logic [dlic_pkg::DW-1:0] fiq_hi;
  logic [dlic_pkg::DW-1:0] byte_mask;
  logic [dlic_pkg::DW-1:0] wr_ones;
  logic fiq_sum;
  logic wr_fire;
  logic [dlic_pkg::AW-1:0] wr_word;
  logic [dlic_pkg::AW-1:0] rd_word;
  logic soft_irq;
  logic soft_fiq;

  // sources may come from other domains or pins, so they are synchronised;
  // a request shorter than one clk_sys period can be lost
  dlic_sync #(
    .W(dlic_pkg::NSRC)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(src),
    .q(src_sync)
  );

  // place each source at its bit of the shared map
  generate
    for (genvar i = 0; i < 32; i++) begin : g_map
      if (i == 0 || i == 1 || i == 6 || i == 15 || i > 18) begin : g_zero
        assign src_map[i] = 1'b0;
      end else begin : g_src
        localparam int unsigned K = (i < 6) ? i - 2 : ((i < 15) ? i - 3 : i - 4);
        assign src_map[dlic_pkg::src_bit(K)] = src_sync[K];
      end
    end
  endgenerate

  // write strobes widen into a bit mask
  generate
    for (genvar b = 0; b < 4; b++) begin : g_strb
      assign byte_mask[b*8 +: 8] = {8{s.w_strb[b]}};
    end
  endgenerate

  assign soft_irq = s.soft_cfg[dlic_pkg::CFG_SOFT_IRQ];
  assign soft_fiq = s.soft_cfg[dlic_pkg::CFG_SOFT_FIQ];

  // status words; soft bits bypass the enables since they are non-maskable
  always_comb begin
    fiq_hi = (src_map & s.fiq_en);
    fiq_hi[dlic_pkg::BIT_SOFT] = soft_fiq;
    fiq_sum = |fiq_hi[31:1];
    irq_raw = src_map;
    irq_raw[dlic_pkg::BIT_SOFT] = soft_irq;
    irq_raw[dlic_pkg::BIT_SUM] = fiq_sum;
    fiq_raw = src_map;
    fiq_raw[dlic_pkg::BIT_SOFT] = soft_fiq;
    fiq_raw[dlic_pkg::BIT_SUM] = fiq_sum;
    irq_masked = src_map & s.irq_en;
    irq_masked[dlic_pkg::BIT_SOFT] = soft_irq;
    fiq_masked = fiq_hi;
    fiq_masked[dlic_pkg::BIT_SUM] = fiq_sum;
  end

  assign wr_fire = s.aw_have && s.w_have && !s.bvalid;
  assign wr_word = s.aw_addr & dlic_pkg::WORD_MASK;
  assign rd_word = axi_req.araddr & dlic_pkg::WORD_MASK;
  // enable bits exist only for real sources, so bit 1 is inert
  assign wr_ones = s.w_data & byte_mask & dlic_pkg::SRC_MASK;

  // bus slave, register writes and the power-down wake
  always_comb begin
    next_s = s;
    next_s.wake = 1'b0;
    if (axi_req.awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.w_data = axi_req.wdata;
      next_s.w_strb = axi_req.wstrb;
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    // both halves held: apply the write and answer
    if (wr_fire) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = dlic_pkg::RESP_OKAY;
      case (wr_word)
        dlic_pkg::OFF_IRQ_EN: begin
          next_s.irq_en = s.irq_en | wr_ones;
          next_s.fiq_en = s.fiq_en & ~wr_ones;
        end
        dlic_pkg::OFF_FIQ_EN: begin
          next_s.fiq_en = s.fiq_en | wr_ones;
          next_s.irq_en = s.irq_en & ~wr_ones;
        end
        // clearing both masks is allowed at any time
        dlic_pkg::OFF_IRQ_CLR: begin
          next_s.irq_en = s.irq_en & ~wr_ones;
        end
        dlic_pkg::OFF_FIQ_CLR: begin
          next_s.fiq_en = s.fiq_en & ~wr_ones;
        end
        dlic_pkg::OFF_SOFT_CFG: begin
          next_s.soft_cfg = ((s.soft_cfg & ~byte_mask) | (s.w_data & byte_mask))
                            & dlic_pkg::CFG_MASK;
        end
        // status registers are read-only: write is accepted and dropped
        dlic_pkg::OFF_IRQ_RAW, dlic_pkg::OFF_IRQ_MSK,
        dlic_pkg::OFF_FIQ_RAW, dlic_pkg::OFF_FIQ_MSK: begin
          next_s.bresp = dlic_pkg::RESP_OKAY;
        end
        default: begin
          next_s.bresp = dlic_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    // read answers one cycle after the address is taken
    if (axi_req.arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = dlic_pkg::RESP_OKAY;
      case (rd_word)
        dlic_pkg::OFF_IRQ_RAW: next_s.rdata = irq_raw;
        dlic_pkg::OFF_IRQ_EN: next_s.rdata = s.irq_en;
        dlic_pkg::OFF_IRQ_MSK: next_s.rdata = irq_masked;
        dlic_pkg::OFF_FIQ_RAW: next_s.rdata = fiq_raw;
        dlic_pkg::OFF_FIQ_EN: next_s.rdata = s.fiq_en;
        dlic_pkg::OFF_FIQ_MSK: next_s.rdata = fiq_masked;
        dlic_pkg::OFF_SOFT_CFG: next_s.rdata = s.soft_cfg;
        // clear registers are write-only and read back as zero
        dlic_pkg::OFF_IRQ_CLR, dlic_pkg::OFF_FIQ_CLR: next_s.rdata = dlic_pkg::ZERO32;
        default: begin
          next_s.rdata = dlic_pkg::ZERO32;
          next_s.rresp = dlic_pkg::RESP_SLVERR;
        end
      endcase
    end
    // ready only while nothing is parked, so one write and one read at a time
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    // core stays down once woken with recognition off; only reset frees it
    if (power_down && core_irq_off && !s.hold && ((|irq_masked) || fiq_sum)) begin
      next_s.wake = 1'b1;
      next_s.hold = 1'b1;
      next_s.pctl = dlic_pkg::PWR_PERIPH_ONLY;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // the two request lines to the core
  dlic_reqline #(
    .LO(0)
  ) u_irq_line (
    .clk_sys(clk_sys),
    .rst(rst),
    .masked(irq_masked),
    .req(irq_req)
  );

  dlic_reqline #(
    .LO(1)
  ) u_fiq_line (
    .clk_sys(clk_sys),
    .rst(rst),
    .masked(fiq_masked),
    .req(fiq_req)
  );

  // outputs from state flip-flops
  assign axi_rsp.awready = s.awready;
  assign axi_rsp.wready = s.wready;
  assign axi_rsp.bvalid = s.bvalid;
  assign axi_rsp.bresp = s.bresp;
  assign axi_rsp.arready = s.arready;
  assign axi_rsp.rvalid = s.rvalid;
  assign axi_rsp.rdata = s.rdata;
  assign axi_rsp.rresp = s.rresp;
  assign periph_wake = s.wake;
  assign core_hold = s.hold;
  assign power_ctl = s.pctl;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  en_exclusive_a: assert property ((s.irq_en & s.fiq_en) == dlic_pkg::ZERO32)
    else $error("source enabled on both levels");

  soft_en_inert_a: assert property (!s.irq_en[1] && !s.fiq_en[1] && !s.irq_en[0])
    else $error("soft or summary bit set in an enable mask");

  raw_follows_a: assert property (##3 irq_raw[2] == $past(src.timer[0], 2))
    else $error("raw status does not follow timer0 after two stages");

  irq_line_a: assert property (##1 irq_req == $past(|irq_masked))
    else $error("normal request not the OR of masked bits one cycle late");

  fiq_line_a: assert property (fiq_sum |=> fiq_req)
    else $error("fast request missing after fast masked bit");

  summary_bit_a: assert property (irq_raw[0] == fiq_masked[0] && fiq_raw[0] == fiq_sum)
    else $error("summary bit differs between levels");

  clear_write_a: assert property (wr_fire && wr_word == dlic_pkg::OFF_IRQ_CLR
      |=> (s.irq_en & $past(wr_ones)) == dlic_pkg::ZERO32)
    else $error("enable clear left a bit set");

  fast_set_a: assert property (wr_fire && wr_word == dlic_pkg::OFF_FIQ_EN
      |=> (s.irq_en & $past(wr_ones)) == dlic_pkg::ZERO32
          && (s.fiq_en & $past(wr_ones)) == $past(wr_ones))
    else $error("fast enable did not displace normal enable");

  soft_irq_a: assert property (soft_irq |-> irq_raw[1] && irq_masked[1] ##1 irq_req)
    else $error("soft normal interrupt not raised");

  soft_fiq_a: assert property (soft_fiq |-> fiq_raw[1] && fiq_masked[1])
    else $error("soft fast interrupt not raised");

  wake_hold_a: assert property (periph_wake |-> core_hold
      && power_ctl == dlic_pkg::PWR_PERIPH_ONLY ##1 !periph_wake [*8])
    else $error("wake did not hold the core down");

  write_answer_a: assert property (wr_fire |=> axi_rsp.bvalid && !axi_rsp.awready)
    else $error("write not answered one cycle after both halves");

  // a read is answered on the edge after its address is taken
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
      |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read not answered one cycle after the address");

  // setting a normal enable bit takes it away from the fast level
  normal_set_a: assert property (wr_fire && wr_word == dlic_pkg::OFF_IRQ_EN
      |=> (s.fiq_en & $past(wr_ones)) == dlic_pkg::ZERO32
          && (s.irq_en & $past(wr_ones)) == $past(wr_ones))
    else $error("normal enable did not displace fast enable");

  // fast clear touches only the fast mask
  fast_clear_a: assert property (wr_fire && wr_word == dlic_pkg::OFF_FIQ_CLR
      |=> (s.fiq_en & $past(wr_ones)) == dlic_pkg::ZERO32
          && s.irq_en == $past(s.irq_en))
    else $error("fast enable clear missed a bit or touched the normal mask");

  // the normal raw status register ignores writes, so the masks must not move
  status_write_a: assert property (wr_fire && wr_word == dlic_pkg::OFF_IRQ_RAW
      |=> s.irq_en == $past(s.irq_en) && s.fiq_en == $past(s.fiq_en))
    else $error("write to a status register changed an enable mask");

  // masked words are raw AND enable outside the summary and soft bits
  irq_masked_a: assert property (
      irq_masked[31:2] == (irq_raw[31:2] & s.irq_en[31:2]))
    else $error("normal masked status is not raw AND enable");

  fiq_masked_a: assert property (
      fiq_masked[31:2] == (fiq_raw[31:2] & s.fiq_en[31:2]))
    else $error("fast masked status is not raw AND enable");

  // reserved map positions never carry a source
  map_gaps_a: assert property (
      (src_map & ~dlic_pkg::SRC_MASK) == dlic_pkg::ZERO32)
    else $error("reserved map bit set");

  soft_rsvd_a: assert property (
      (s.soft_cfg & ~dlic_pkg::CFG_MASK) == dlic_pkg::ZERO32)
    else $error("reserved soft config bit set");

  // a soft fast request reaches the core line whatever the enables say
  soft_fiq_line_a: assert property (soft_fiq |=> fiq_req)
    else $error("soft fast interrupt did not raise the fast line");

  // no wake unless powered down with recognition off; once held, stays held
  wake_cause_a: assert property (!(power_down && core_irq_off) |=> !periph_wake)
    else $error("wake without power-down and recognition off");

  hold_sticky_a: assert property (core_hold |=> core_hold
      && power_ctl == dlic_pkg::PWR_PERIPH_ONLY)
    else $error("core hold or power setting dropped before reset");

  irq_rise_c: cover property ($rose(irq_req));
  fiq_rise_c: cover property ($rose(fiq_req));
  wake_c: cover property ($rose(periph_wake));
  clear_c: cover property (wr_fire && wr_word == dlic_pkg::OFF_FIQ_CLR);
  soft_c: cover property (soft_irq && soft_fiq);
endmodule
`default_nettype wire

//--- tb/dlic_src_model.sv
// peripheral source model driving request levels into the controller
`timescale 1ns/1ns
`default_nettype none
module dlic_src_model #(
  parameter int unsigned MIN_HOLD = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [14:0] want, // levels the bench asks for
  output dlic_pkg::dlic_src_s src // request levels to the controller
);
  logic [7:0] age;

  // a level only moves once it has stood long enough to pass the synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src <= '0;
      age <= 8'h00;
    end else if (age < MIN_HOLD) begin
      age <= age + 8'h01;
    end else if (want != src) begin
      src <= want;
      age <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- tb/test_dual_level_interrupt_controller.sv
// self-checking testbench of the dual-level interrupt controller
`timescale 1ns/1ns
`default_nettype none
module test_dual_level_interrupt_controller;
  localparam logic [31:0] SM = 32'h0007_7FBC;
  localparam logic [39:0] WT = 40'h04_08_14_18_20;
  logic clk_sys, rst, power_down, core_irq_off;
  dlic_pkg::dlic_axi_req_s req;
  dlic_pkg::dlic_axi_rsp_s rsp;
  dlic_pkg::dlic_src_s src;
  logic irq_req, fiq_req, periph_wake, core_hold;
  logic [7:0] power_ctl;
  logic [14:0] want, sv;
  logic [31:0] en_i, en_f, cfg;
  logic [33:0] qr[$];
  logic [1:0] qb[$];
  logic [33:0] me;
  logic [1:0] mb;
  int err_count, n_tests, cyc, seed;

  dlic_top dut_u (.clk_sys(clk_sys), .rst(rst), .axi_req(req), .axi_rsp(rsp), .src(src),
    .power_down(power_down), .core_irq_off(core_irq_off), .irq_req(irq_req),
    .fiq_req(fiq_req), .periph_wake(periph_wake), .core_hold(core_hold),
    .power_ctl(power_ctl));
  dlic_src_model peer_u (.clk_sys(clk_sys), .rst(rst), .want(want), .src(src));

  task automatic close_out;
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic s, input logic e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask

  // source levels placed at their map positions, gaps at 6 and 15
  function automatic logic [31:0] smap(input logic [14:0] s);
    return {13'h0000, s[14:12], 1'b0, s[11:4], 1'b0, s[3:0], 2'b00};
  endfunction

  // expected register contents from the bench's own copy of the state
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    logic [31:0] m, fm, s;
    m = smap(sv);
    fm = (m & en_f) | {29'h0, cfg[2], 1'b0};
    s = {31'h0, |fm};
    case (a)
      8'h00: return m | {30'h0, cfg[1], 1'b0} | s;
      8'h04: return en_i;
      8'h0C: return (m & en_i) | {30'h0, cfg[1], 1'b0};
      8'h10: return m | {29'h0, cfg[2], 1'b0} | s;
      8'h14: return en_f;
      8'h1C: return fm | s;
      8'h20: return cfg;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // one write; both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    logic [31:0] dm;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_sys);
    qb.push_back((a <= 8'h20) ? 2'h0 : 2'h2);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    while (pa || pw) begin
      @(negedge clk_sys);
      ta = pa && (rsp.awready === 1'b1);
      tw = pw && (rsp.wready === 1'b1);
      @(posedge clk_sys);
      if (ta) begin
        req.awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        req.wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge clk_sys); while (rsp.bvalid !== 1'b1);
    @(posedge clk_sys);
    // only the byte lanes that were strobed reach the register
    dm = d & {{8{req.wstrb[3]}}, {8{req.wstrb[2]}}, {8{req.wstrb[1]}}, {8{req.wstrb[0]}}};
    case (a)
      8'h04: begin
        en_i = en_i | (dm & SM);
        en_f = en_f & ~(dm & SM);
      end
      8'h08: en_i = en_i & ~dm;
      8'h14: begin
        en_f = en_f | (dm & SM);
        en_i = en_i & ~(dm & SM);
      end
      8'h18: en_f = en_f & ~dm;
      8'h20: cfg = dm & 32'h0000_0006;
      default: ;
    endcase
  endtask

  // one read; the monitor compares the answer
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    qr.push_back({(a <= 8'h20) ? 2'h0 : 2'h2, exp_rd(a)});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(negedge clk_sys); while (rsp.arready !== 1'b1);
    @(posedge clk_sys);
    req.arvalid <= 1'b0;
    do @(negedge clk_sys); while (rsp.rvalid !== 1'b1);
    @(posedge clk_sys);
  endtask

  task automatic rd_all;
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4));
    end
  endtask

  // request lines looked at mid-cycle, well after the last change
  task automatic chk_lines;
    logic [31:0] m, f;
    @(negedge clk_sys);
    m = exp_rd(8'h0C);
    f = exp_rd(8'h1C);
    chk1("irq_req", irq_req, |m);
    chk1("fiq_req", fiq_req, f[0]);
  endtask

  // wait covers the model's hold, the synchroniser and the line register
  task automatic set_src(input logic [14:0] v);
    @(posedge clk_sys);
    want <= v;
    sv = v;
    repeat (10) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // handshakes are judged at the falling edge, where they are settled
  always @(negedge clk_sys) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      me = qr.pop_front();
      chk32("rdata", rsp.rdata, me[31:0]);
      chk32("rresp", {30'h0, rsp.rresp}, {30'h0, me[33:32]});
    end
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
      mb = qb.pop_front();
      chk32("bresp", {30'h0, rsp.bresp}, {30'h0, mb});
    end
  end

  // hang guard, far above the 1200 or so cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    int k;
    seed = 56;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    rst = 1'b1;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    power_down = 1'b0;
    core_irq_off = 1'b0;
    want = '0;
    sv = '0;
    en_i = '0;
    en_f = '0;
    cfg = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk32("power_ctl", {24'h0, power_ctl}, 32'h0000_0000);
    rd_all();
    // every address written with all ones, read-only and unmapped ones too
    for (int i = 0; i < 10; i++) begin
      wr(8'(i * 4), 32'hFFFF_FFFF);
      rd_all();
    end
    wr(8'h04, 32'hFFFF_FFFF);
    wr(8'h14, 32'h0000_0024);
    wr(8'h04, 32'h0000_0004);
    // one lane only: the clear must leave the other bytes of the mask alone
    req.wstrb <= 4'h2;
    wr(8'h08, 32'hFFFF_FFFF);
    req.wstrb <= 4'hF;
    rd_all();
    // random sources against random enable and soft writes
    for (int i = 0; i < 16; i++) begin
      set_src(15'($random(seed)));
      k = $unsigned($random(seed)) % 5;
      wr(WT[8 * k +: 8], 32'($random(seed)));
      rd_all();
      chk_lines();
    end
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h18, 32'hFFFF_FFFF);
    wr(8'h20, 32'h0000_0000);
    rd_all();
    chk_lines();
    // power-down wake, first with core recognition on, then off
    wr(8'h04, 32'hFFFF_FFFF);
    set_src(15'h7FFF);
    power_down <= 1'b1;
    repeat (6) @(negedge clk_sys);
    chk1("core_hold", core_hold, 1'b0);
    @(posedge clk_sys);
    core_irq_off <= 1'b1;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (periph_wake !== 1'b1 && k < 8);
    chk1("periph_wake", periph_wake, 1'b1);
    chk1("core_hold", core_hold, 1'b1);
    chk32("power_ctl", {24'h0, power_ctl}, 32'h0000_0071);
    @(negedge clk_sys);
    chk1("periph_wake", periph_wake, 1'b0);
    repeat (4) @(negedge clk_sys);
    chk1("core_hold", core_hold, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
